// *** shared/smbm_pkg.sv ***
// shared memory bus master port: constants, carriers and state record
// assumes a single 125 MHz clock domain; pin levels are resolved by the bench
package smbm_pkg;

   // ------------------------------------------------------------------
   // widths and pin field positions
   // ------------------------------------------------------------------
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned WADDR_LSB = 2;   // word address starts at bit 2
   localparam int unsigned WADDR_MSB = 27;
   localparam int unsigned UPPER_LSB = 28;  // the four upper lines 31..28
   localparam int unsigned HALF_SEL_BIT = 1; // selects upper half for word transfers

   // ------------------------------------------------------------------
   // byte lane and transfer size codes
   // ------------------------------------------------------------------
   // little endian lanes are active low, one bit per byte
   localparam logic [3:0] LANES_LONG = 4'h0;
   localparam logic [3:0] LANES_WORD_LO = 4'hc;
   localparam logic [3:0] LANES_WORD_HI = 4'h3;
   // big endian: number of bytes still to transfer
   localparam logic [3:0] SIZE_LONG = 4'h4;
   localparam logic [3:0] SIZE_WORD = 4'h2;
   // parity sense: 0 gives even parity over byte plus parity bit
   localparam logic PARITY_ODD = 1'b0;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic RST_CHECK_OK = 1'b1;
   localparam logic RST_DONE_IN = 1'b0;  // cycle-done idles low
   localparam logic RST_ACK_IN_N = 1'b1; // acknowledge idles high
   localparam logic RST_STRAP = 1'b0;
   localparam int unsigned SYNC_STAGES = 3;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic write;             // 1 = write to memory
      logic long_xfer;         // 1 = 32-bit long word, 0 = 16-bit word
      logic [ADDR_W-1:0] addr; // byte address
      logic [DATA_W-1:0] wdata;
   } smbm_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] rdata; // word transfers return in bits 15:0
      logic err;                // cycle ended by bus error
      logic parity_ok;          // read parity correct (parity mode only)
   } smbm_resp_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETUP,
      ST_WAIT,
      ST_END
   } smbm_fsm_t;

   typedef struct packed {
      smbm_fsm_t fsm;
      logic big_endian;
      logic parity_en;
      logic write;
      logic long_xfer;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [3:0] lanes;
      logic bus_oe;     // address, lanes, qualifier driven
      logic qual;       // address qualifier asserted
      logic dstb;       // data strobe asserted
      logic chk_oe;     // parity check output driven
      logic chk_ok;
      logic resp_valid;
      smbm_resp_t resp;
   } smbm_state_t;

endpackage : smbm_pkg

// *** core/smbm_sync.sv ***
// three-stage input synchroniser with agreement filter
// assumes input comes from a pin outside the mclk domain
`timescale 1ns/1ps
`default_nettype none
module smbm_sync #(
   parameter logic RST_VAL = 1'b0
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // pin side
   input wire logic pin_i,
   // core side
   output logic lvl_o
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } smbm_sync_t;

   smbm_sync_t st_q;
   smbm_sync_t st_d;

   // the first stage feeds only the second; the level moves when 2 and 3 agree
   always_comb begin
      st_d = st_q;
      st_d.s1 = pin_i;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      if (st_q.s2 == st_q.s3) begin
         st_d.lvl = st_q.s3;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_q <= {4{RST_VAL}};
      end else begin
         st_q <= st_d;
      end
   end

   assign lvl_o = st_q.lvl;

endmodule : smbm_sync
`default_nettype wire

// *** core/smbm_port.sv ***
// shared memory bus master port: runs one word or long word cycle per request
// assumes straps are static, pins are resolved from the enables by the board
// Summary of operation
// [RULE_01] upper lines are address outputs, floated when idle
// [RULE_02] parity mode: upper lines carry byte parity
// [RULE_03] word address from bit 2, floated when idle
// [RULE_04] both word and long word transfers
// [RULE_05] little endian lanes mark byte offset
// [RULE_06] big endian lanes give bytes remaining
// [RULE_07] lane outputs float outside own cycles
// [RULE_08] data driven on writes, received on reads
// [RULE_09] big endian data strobe marks data phase
// [RULE_10] parity check output high good, low bad
// [RULE_11] address status low while cycle valid
// [RULE_12] address valid at address strobe fall
// [RULE_13] qualifier active low, floated when idle
// [RULE_14] strap low little endian, high big endian
// [RULE_15] top two lines carry parity of bytes 3,2
// [RULE_16] cycle-done ends little endian cycles, latches data
// [RULE_17] acknowledge fall ends big endian cycles
// [RULE_18] address and lanes stable through whole cycle
`timescale 1ns/1ps
`default_nettype none
module smbm_port (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // straps
   input wire logic big_endian_strap,
   input wire logic parity_strap,
   // internal request side
   input wire logic req_valid,
   input wire smbm_pkg::smbm_req_t req,
   output logic req_ready,
   output logic resp_valid,
   output smbm_pkg::smbm_resp_t resp,
   // upper address / parity lines 31..28
   input wire logic [3:0] upper_i,
   output logic [3:0] upper_o,
   output logic [3:0] upper_oe,
   // word address and byte lanes
   output logic [25:0] word_addr_o,
   output logic word_addr_oe,
   output logic [3:0] byte_lane_select,
   output logic byte_lane_oe,
   // data bus
   input wire logic [31:0] data_i,
   output logic [31:0] data_o,
   output logic data_oe,
   // strobes and direction
   output logic data_strobe_out,
   output logic data_strobe_oe,
   output logic address_status_out_n,
   output logic address_status_oe,
   output logic write_dir_o,
   output logic write_dir_oe,
   // cycle termination
   input wire logic cycle_done_in,
   input wire logic transfer_acknowledge_in_n,
   input wire logic bus_error_in_n
);

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   logic be_lvl;
   logic par_lvl;
   logic done_lvl;
   logic ack_n_lvl;
   logic err_n_lvl;

   smbm_sync #(.RST_VAL(smbm_pkg::RST_STRAP)) u_sync_be (
      .mclk(mclk), .nrst(nrst), .pin_i(big_endian_strap), .lvl_o(be_lvl));
   smbm_sync #(.RST_VAL(smbm_pkg::RST_STRAP)) u_sync_par (
      .mclk(mclk), .nrst(nrst), .pin_i(parity_strap), .lvl_o(par_lvl));
   smbm_sync #(.RST_VAL(smbm_pkg::RST_DONE_IN)) u_sync_done (
      .mclk(mclk), .nrst(nrst), .pin_i(cycle_done_in), .lvl_o(done_lvl));
   smbm_sync #(.RST_VAL(smbm_pkg::RST_ACK_IN_N)) u_sync_ack (
      .mclk(mclk), .nrst(nrst), .pin_i(transfer_acknowledge_in_n), .lvl_o(ack_n_lvl));
   smbm_sync #(.RST_VAL(smbm_pkg::RST_ACK_IN_N)) u_sync_err (
      .mclk(mclk), .nrst(nrst), .pin_i(bus_error_in_n), .lvl_o(err_n_lvl));

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   smbm_pkg::smbm_state_t st_q;
   smbm_pkg::smbm_state_t st_d;
   logic term_hit;
   logic term_busy;
   logic [3:0] par_gen;
   logic [3:0] par_bad;
   logic [3:0] lane_on;

   // termination differs per personality; bus error ends either kind
   assign term_hit = (st_q.big_endian ? !ack_n_lvl : done_lvl) || !err_n_lvl; // [RULE_16] [RULE_17]
   assign term_busy = (st_q.big_endian ? !ack_n_lvl : done_lvl) || !err_n_lvl;

   // byte parity of outgoing data and check of incoming bytes
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         par_gen[i] = ^st_q.wdata[8*i +: 8] ^ smbm_pkg::PARITY_ODD; // [RULE_02] [RULE_15]
         par_bad[i] = (^data_i[8*i +: 8] ^ smbm_pkg::PARITY_ODD) != upper_i[i];
         lane_on[i] = !st_q.lanes[i];
      end
   end

   // ------------------------------------------------------------------
   // bus cycle sequencer
   // ------------------------------------------------------------------
   // the personality is latched per cycle so a strap glitch cannot split a cycle
   always_comb begin
      st_d = st_q;
      st_d.resp_valid = 1'b0;
      unique case (st_q.fsm)
         smbm_pkg::ST_IDLE: begin
            if (req_valid) begin
               st_d.fsm = smbm_pkg::ST_SETUP;
               st_d.big_endian = be_lvl; // [RULE_14]
               st_d.parity_en = par_lvl && !be_lvl;
               st_d.write = req.write;
               st_d.long_xfer = req.long_xfer; // [RULE_04]
               st_d.addr = req.addr;
               st_d.wdata = req.wdata;
               // word data rides on the half that its address selects
               if (!req.long_xfer && req.addr[smbm_pkg::HALF_SEL_BIT]) begin
                  st_d.wdata = {req.wdata[15:0], 16'h0000};
               end else if (!req.long_xfer) begin
                  st_d.wdata = {16'h0000, req.wdata[15:0]};
               end
               if (be_lvl) begin
                  st_d.lanes = req.long_xfer ? smbm_pkg::SIZE_LONG
                                             : smbm_pkg::SIZE_WORD; // [RULE_06]
               end else if (req.long_xfer) begin
                  st_d.lanes = smbm_pkg::LANES_LONG; // [RULE_05]
               end else begin
                  st_d.lanes = req.addr[smbm_pkg::HALF_SEL_BIT] ? smbm_pkg::LANES_WORD_HI
                                                              : smbm_pkg::LANES_WORD_LO;
               end
               st_d.bus_oe = 1'b1; // [RULE_18]
               // little endian qualifies at once; big endian lets address settle first
               st_d.qual = !be_lvl; // [RULE_11] [RULE_12]
               st_d.chk_oe = par_lvl && !be_lvl;
            end
         end
         smbm_pkg::ST_SETUP: begin
            st_d.fsm = smbm_pkg::ST_WAIT;
            st_d.qual = 1'b1; // [RULE_12]
            st_d.dstb = st_q.big_endian; // [RULE_09]
         end
         smbm_pkg::ST_WAIT: begin
            if (term_hit) begin
               st_d.fsm = smbm_pkg::ST_END;
               st_d.resp_valid = 1'b1;
               st_d.resp.err = !err_n_lvl;
               st_d.resp.rdata = 32'h0000_0000;
               st_d.resp.parity_ok = smbm_pkg::RST_CHECK_OK;
               if (!st_q.write) begin
                  // latch read data on termination, words returned low aligned
                  if (st_q.long_xfer) begin
                     st_d.resp.rdata = data_i; // [RULE_08]
                  end else if (st_q.addr[smbm_pkg::HALF_SEL_BIT]) begin
                     st_d.resp.rdata = {16'h0000, data_i[31:16]};
                  end else begin
                     st_d.resp.rdata = {16'h0000, data_i[15:0]};
                  end
                  if (st_q.parity_en) begin
                     st_d.chk_ok = !(|(par_bad & lane_on)); // [RULE_10]
                     st_d.resp.parity_ok = st_d.chk_ok;
                  end
               end
               st_d.bus_oe = 1'b0; // [RULE_07] [RULE_13]
               st_d.qual = 1'b0;
               st_d.dstb = 1'b0;
            end
         end
         smbm_pkg::ST_END: begin
            // wait for the terminator to go away so one level is one cycle
            if (!term_busy) begin
               st_d.fsm = smbm_pkg::ST_IDLE;
               st_d.chk_oe = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_q <= '{fsm: smbm_pkg::ST_IDLE, chk_ok: smbm_pkg::RST_CHECK_OK,
                   resp: '{rdata: 32'h0000_0000, err: 1'b0,
                           parity_ok: smbm_pkg::RST_CHECK_OK},
                   default: '0};
      end else begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------------
   assign req_ready = (st_q.fsm == smbm_pkg::ST_IDLE);
   assign resp_valid = st_q.resp_valid;
   assign resp = st_q.resp;

   // upper lines: address in non-parity modes, parity on writes in parity mode
   assign upper_o = st_q.parity_en ? par_gen
                                   : st_q.addr[smbm_pkg::UPPER_LSB +: 4]; // [RULE_01] [RULE_02]
   assign upper_oe = {4{st_q.bus_oe && (!st_q.parity_en || st_q.write)}}; // [RULE_15]
   assign word_addr_o = st_q.addr[smbm_pkg::WADDR_MSB:smbm_pkg::WADDR_LSB]; // [RULE_03]
   assign word_addr_oe = st_q.bus_oe;
   assign byte_lane_select = st_q.lanes;
   assign byte_lane_oe = st_q.bus_oe; // [RULE_07]
   assign data_o = st_q.wdata;
   assign data_oe = st_q.bus_oe && st_q.write; // [RULE_08]
   // one pin: data strobe in big endian, parity check in little endian parity
   assign data_strobe_out = st_q.big_endian ? !st_q.dstb : st_q.chk_ok; // [RULE_09] [RULE_10]
   assign data_strobe_oe = st_q.big_endian ? st_q.bus_oe : st_q.chk_oe;
   assign address_status_out_n = !st_q.qual; // [RULE_13]
   assign address_status_oe = st_q.bus_oe;
   // little endian: high means write; big endian: high means read
   assign write_dir_o = st_q.big_endian ? !st_q.write : st_q.write;
   assign write_dir_oe = st_q.bus_oe;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   // qualifier low and driven, as a plain expression so it can be combined freely
   logic qual_on;
   assign qual_on = !address_status_out_n && address_status_oe;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence s_taken;
      req_valid && req_ready;
   endsequence
   sequence s_qualified;
      qual_on;
   endsequence

   idle_float_a: assert property (req_ready |-> !word_addr_oe && !byte_lane_oe
      && !address_status_oe && !data_oe) // [RULE_03]
      else $error("bus pins driven while idle");
   upper_float_a: assert property (req_ready |-> upper_oe == 4'h0) // [RULE_01]
      else $error("upper lines driven while idle");
   le_qual_a: assert property (s_taken ##1 !st_q.big_endian |-> s_qualified [*2]) // [RULE_11]
      else $error("address status not asserted with address");
   be_setup_a: assert property (s_taken ##1 st_q.big_endian |-> address_status_out_n
      && word_addr_oe ##1 qual_on && !data_strobe_out) // [RULE_12]
      else $error("address strobe fell without address setup");
   addr_hold_a: assert property (qual_on && $past(qual_on) |->
      $stable(word_addr_o) && $stable(byte_lane_select)) // [RULE_18]
      else $error("address moved during cycle");
   lane_code_a: assert property (qual_on && st_q.big_endian |->
      byte_lane_select == (st_q.long_xfer ? 4'h4 : 4'h2)) // [RULE_06]
      else $error("size code wrong");
   lane_le_a: assert property (qual_on && !st_q.big_endian && st_q.long_xfer
      |-> byte_lane_select == 4'h0) // [RULE_05]
      else $error("lanes wrong for long word");
   term_resp_a: assert property (qual_on && term_hit && st_q.fsm == smbm_pkg::ST_WAIT
      |=> resp_valid && !address_status_oe) // [RULE_16]
      else $error("cycle not ended on termination");
   write_data_a: assert property (s_qualified |-> data_oe == st_q.write) // [RULE_08]
      else $error("data drive does not follow direction");
   parity_gen_a: assert property (data_oe && st_q.parity_en |->
      upper_o == ({^data_o[31:24], ^data_o[23:16], ^data_o[15:8], ^data_o[7:0]}
      ^ {4{smbm_pkg::PARITY_ODD}})) // [RULE_02] [RULE_15]
      else $error("byte parity wrong");
   check_out_a: assert property (resp_valid && st_q.parity_en && !st_q.write |->
      data_strobe_out == resp.parity_ok && data_strobe_oe) // [RULE_10]
      else $error("parity check pin mismatch");

endmodule : smbm_port
`default_nettype wire

// *** tb/smbm_mem_model.sv ***
// shared memory behind the bus master port, answering each cycle after a set delay
// assumes bus pins arrive resolved by the bench; one clock, reset active low
`timescale 1ns/1ps
`default_nettype none
module smbm_mem_model (
   // clock, reset and bus personality
   input wire logic mclk,
   input wire logic nrst,
   input wire logic be,
   input wire logic par,
   // bench controls: answer delay, spoil parity of byte 0
   input wire logic [3:0] dly,
   input wire logic bad_par,
   // pins seen from the port
   input wire logic [25:0] waddr,
   input wire logic [3:0] lanes,
   input wire logic cyc,
   input wire logic dir,
   input wire logic [31:0] dbus,
   // answers
   output logic done,
   output logic ack_n,
   output logic [31:0] rd,
   output logic rd_oe,
   output logic [3:0] par_o
);
   // ------------------------------------------------------------
   // storage and answer logic
   // ------------------------------------------------------------
   logic [31:0] mem [16];
   logic [31:0] pat_q = 32'h0f0f_3c3c;
   logic [3:0] cnt_q = 4'h0;
   logic fin_q = 1'b0;
   logic wr;
   logic [31:0] m;
   initial for (int i = 0; i < 16; i++) mem[i] = 32'hc3a5_0000 + i * 32'h0001_0111;
   assign wr = be ? !dir : dir;
   assign m = mem[waddr[3:0]];
   // released lines flip every cycle so a stale value can never pass
   assign rd_oe = cyc && !wr;
   assign rd = rd_oe ? m : pat_q;
   assign par_o = (rd_oe && par) ? {^m[31:24], ^m[23:16], ^m[15:8], ^m[7:0] ^ bad_par}
      ^ {4{smbm_pkg::PARITY_ODD}} : pat_q[3:0];
   // terminator held until the port floats its qualifier
   assign done = fin_q && !be;
   assign ack_n = !(fin_q && be);
   always @(posedge mclk or negedge nrst) begin
      pat_q <= ~pat_q;
      if (!nrst || !cyc) begin
         cnt_q <= 4'h0;
         fin_q <= 1'b0;
      end else if (!fin_q) begin
         cnt_q <= cnt_q + 4'h1;
         if (cnt_q == dly) begin
            fin_q <= 1'b1;
            // word writes in big endian mode are not modelled
            for (int b = 0; b < 4; b++) begin
               if (wr && (be ? lanes == smbm_pkg::SIZE_LONG : !lanes[b])) begin
                  mem[waddr[3:0]][b*8 +: 8] <= dbus[b*8 +: 8];
               end
            end
         end
      end
   end
endmodule : smbm_mem_model
`default_nettype wire

// *** tb/tb_top.sv ***
// bench for the shared memory bus master port: corner and random transfers
// assumes the memory model answers every cycle; bus error is never raised
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ------------------------------------------------------------
   // clock, straps, pins
   // ------------------------------------------------------------
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic be_s = 1'b0;
   logic par_s = 1'b0;
   logic req_valid = 1'b0;
   logic bad_par = 1'b0;
   logic [3:0] dly = 4'h0;
   smbm_pkg::smbm_req_t req = '0;
   smbm_pkg::smbm_resp_t resp;
   logic req_ready, resp_valid, waddr_oe, lane_oe, data_oe, ds_out, ds_oe;
   logic qual_n, qual_oe, dir, dir_oe, done, ack_n, rd_oe;
   logic [3:0] upper_o, upper_oe, upper_i, lanes, par_o;
   logic [25:0] waddr;
   logic [31:0] data_o, rd, dbus;
   logic [31:0] exp_mem [16];
   int mismatches = 0;
   int n_checks = 0;
   always #4 mclk = ~mclk;
   // a released line shows whatever the other party puts there
   assign dbus = data_oe ? data_o : rd;
   assign upper_i = (upper_oe & upper_o) | (~upper_oe & par_o);
   smbm_port DUT (.mclk(mclk), .nrst(nrst), .big_endian_strap(be_s), .parity_strap(par_s),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp_valid(resp_valid),
      .resp(resp), .upper_i(upper_i), .upper_o(upper_o), .upper_oe(upper_oe),
      .word_addr_o(waddr), .word_addr_oe(waddr_oe), .byte_lane_select(lanes),
      .byte_lane_oe(lane_oe), .data_i(dbus), .data_o(data_o), .data_oe(data_oe),
      .data_strobe_out(ds_out), .data_strobe_oe(ds_oe), .address_status_out_n(qual_n),
      .address_status_oe(qual_oe), .write_dir_o(dir), .write_dir_oe(dir_oe),
      .cycle_done_in(done), .transfer_acknowledge_in_n(ack_n), .bus_error_in_n(1'b1));
   smbm_mem_model mem_i (.mclk(mclk), .nrst(nrst), .be(be_s), .par(par_s && !be_s),
      .dly(dly), .bad_par(bad_par), .waddr(waddr), .lanes(lanes), .cyc(qual_oe),
      .dir(dir), .dbus(dbus), .done(done), .ack_n(ack_n), .rd(rd), .rd_oe(rd_oe),
      .par_o(par_o));
   // ------------------------------------------------------------
   // expectations, compare and verdict
   // ------------------------------------------------------------
   function automatic logic [3:0] exp_lanes(input logic b, input logic lng, input logic a1);
      if (lng) return b ? smbm_pkg::SIZE_LONG : smbm_pkg::LANES_LONG;
      if (b) return smbm_pkg::SIZE_WORD;
      return a1 ? smbm_pkg::LANES_WORD_HI : smbm_pkg::LANES_WORD_LO;
   endfunction : exp_lanes
   function automatic logic [3:0] exp_par(input logic [31:0] d);
      return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]} ^ {4{smbm_pkg::PARITY_ODD}};
   endfunction : exp_par
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   // one bus cycle; entered just after an edge, pins watched every cycle
   task automatic xfer(input logic wr, input logic lng, input logic [31:0] a,
      input logic [31:0] wd, input logic bad);
      logic [31:0] mask, m, wexp, rmask, rexp;
      logic p, ok, ds_low;
      int n, seen;
      mask = lng ? 32'hffff_ffff : (a[1] ? 32'hffff_0000 : 32'h0000_ffff);
      wexp = (lng ? wd : {2{wd[15:0]}}) & mask;
      m = exp_mem[a[5:2]];
      rmask = lng ? 32'hffff_ffff : 32'h0000_ffff;
      rexp = lng ? m : 32'(a[1] ? m[31:16] : m[15:0]);
      p = par_s && !be_s;
      ok = !(bad && (lng || !a[1]));
      n = 0;
      seen = 0;
      ds_low = 1'b0;
      req_valid = 1'b1;
      req = {wr, lng, a, wd};
      bad_par = bad;
      dly = 4'($urandom_range(0, 6));
      while (req_ready !== 1'b1 && n < 50) begin
         @(posedge mclk);
         #1;
         n++;
      end
      @(posedge mclk);
      #1;
      req_valid = 1'b0;
      n = 0;
      while (resp_valid !== 1'b1 && n < 300) begin
         if (qual_oe === 1'b1 && qual_n === 1'b0) begin
            seen++;
            chk("addr", 32'(waddr), 32'(a[27:2]));
            chk("lanes", 32'(lanes), 32'(exp_lanes(be_s, lng, a[1])));
            chk("data_oe", 32'(data_oe), 32'(wr));
            chk("dir", 32'({dir_oe, dir}), 32'({1'b1, be_s ? !wr : wr}));
            if (wr) chk("wdata", data_o & mask, wexp);
            if (!p) chk("upper", 32'({upper_oe, upper_o}), 32'({4'hf, a[31:28]}));
            if (p && wr && lng) chk("wpar", 32'(upper_o), 32'(exp_par(wd)));
         end
         if (be_s && ds_oe === 1'b1 && ds_out === 1'b0) ds_low = 1'b1;
         @(posedge mclk);
         #1;
         n++;
      end
      chk("resp_valid", 32'(resp_valid), 32'h1);
      chk("qualifier", 32'(seen > 0), 32'h1);
      chk("float", 32'({upper_oe, waddr_oe, lane_oe, qual_oe, data_oe, dir_oe}), 32'h0);
      chk("err", 32'(resp.err), 32'h0);
      if (be_s) chk("strobe", 32'(ds_low), 32'h1);
      if (!wr) chk("rdata", resp.rdata & rmask, rexp);
      if (p && !wr) chk("parity ok", 32'(resp.parity_ok), 32'(ok));
      if (p && !wr) chk("check pin", 32'({ds_oe, ds_out}), 32'({1'b1, ok}));
      if (!p && !be_s) chk("check idle", 32'(ds_oe), 32'h0);
      if (wr) exp_mem[a[5:2]] = (m & ~mask) | wexp;
   endtask : xfer
   // ------------------------------------------------------------
   // main sequence: each personality after its own reset
   // ------------------------------------------------------------
   initial begin
      logic wr, lng;
      logic [31:0] a;
      for (int i = 0; i < 16; i++) exp_mem[i] = 32'hc3a5_0000 + i * 32'h0001_0111;
      void'($urandom(13));
      for (int md = 0; md < 3; md++) begin
         nrst = 1'b0;
         be_s = (md == 2);
         par_s = (md == 1);
         repeat (16) @(posedge mclk);
         #1;
         chk("reset float", 32'({upper_oe, waddr_oe, lane_oe, qual_oe, data_oe, dir_oe}), 32'h0);
         nrst = 1'b1;
         repeat (6) @(posedge mclk);
         #1;
         // back to back long words, both word halves, a spoilt parity byte
         xfer(1'b1, 1'b1, 32'h9000_0014, 32'h1234_5678, 1'b0);
         xfer(1'b0, 1'b1, 32'h9000_0014, 32'h0, 1'b0);
         if (!be_s) xfer(1'b1, 1'b0, 32'h3000_0016, 32'h0000_beef, 1'b0);
         xfer(1'b0, 1'b0, 32'h3000_0016, 32'h0, par_s);
         xfer(1'b0, 1'b0, 32'h3000_0018, 32'h0, par_s);
         xfer(1'b0, 1'b1, 32'h6000_003c, 32'h0, par_s);
         for (int i = 0; i < 16; i++) begin
            wr = 1'($urandom);
            lng = 1'($urandom) | (be_s & wr);
            a = $urandom & (lng ? 32'hffff_fffc : 32'hffff_fffe);
            xfer(wr, lng, a, $urandom, par_s & ($urandom_range(0, 3) == 0));
         end
      end
      print_verdict();
   end
   // hang guard: about thirty-five times the expected run
   initial begin
      repeat (40000) @(posedge mclk);
      mismatches++;
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
